// File: core/mmtc_edge_detect.sv
// Sampler and rising edge detector for the external counter line
module mmtc_edge_detect (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Line
    input wire logic line_in,
    output logic level,
    output logic rise
);

    // ==========================================================
    // Two successive samples
    logic sample_reg;
    logic prev_reg;

    // Shift the line through two sample stages
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sample_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            sample_reg <= line_in;
            prev_reg <= sample_reg;
        end
    end

    // Compare the two samples
    assign level = sample_reg;
    assign rise = sample_reg & ~prev_reg;

endmodule : mmtc_edge_detect

// File: core/mmtc_pkg.sv
// Package of constants and types for the multimode timer counter
package mmtc_pkg;

    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h18;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h19;
    localparam logic [7:0] ADDR_HIGH_RESTART = 8'h1a;

    // ==========================================================
    // Mode control field positions and reset value
    localparam int MODE_SEL_LO_POS = 0;
    localparam int MODE_SEL_HI_POS = 1;
    localparam logic [1:0] MODE_RESET = 2'h0;

    // ==========================================================
    // Counter widths and reset values
    localparam int COUNT_W = 16;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] LATCH_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;

    // ==========================================================
    // Serial rate divide: one bit per sixteen underflows
    localparam int RATE_DIV = 16;
    localparam logic [3:0] RATE_DIV_LAST = 4'hf;

    // Operating modes, one-hot
    typedef enum logic [3:0] {
        MMTC_INTERVAL = 4'b0001,
        MMTC_PULSE_GEN = 4'b0010,
        MMTC_EVENT = 4'b0100,
        MMTC_WIDTH = 4'b1000
    } mmtc_mode_t;

    // Processor bus access
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mmtc_bus_t;

    // Serial channel control inputs
    typedef struct packed {
        logic enable;
        logic needs_internal_clock;
        logic receiver_shift_mode;
    } mmtc_serial_t;

endpackage : mmtc_pkg

// File: core/mmtc_rate_div.sv
// Divide underflows by sixteen into the serial bit rate strobe
module mmtc_rate_div (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control
    input wire logic enable,
    input wire logic tick,
    output logic bit_strobe
);

    // ==========================================================
    logic [3:0] div_reg;

    // Count underflows while the serial channel is on
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !enable) begin
            div_reg <= 4'h0;
        end else if (tick) begin
            div_reg <= div_reg + 4'h1;
        end
    end

    // One strobe every sixteenth underflow
    assign bit_strobe = enable & tick & (div_reg == mmtc_pkg::RATE_DIV_LAST);

endmodule : mmtc_rate_div

// File: core/mmtc_top.sv
// Multimode 16-bit down counter with reload latch and serial rate output
// Functional notes
// - 16-bit down counter starting from the reload latch in all modes.
// - Modes needing a line take over port A bit four.
// - Read 0x19 gives live count high byte, 0x18 low byte.
// - Reading 0x18 clears the underflow flag.
// - Writes to 0x19/0x18 load latch halves without touching the count.
// - Write 0x1A loads latch high byte then copies latch into counter.
// - Decrement from zero reloads from latch and sets underflow flag.
// - Flag cleared by 0x18 read, 0x1A write or reset.
// - Mode bits 1:0 select interval, pulse, event, width modes.
// - Reset selects interval timer mode.
// - Event mode counts line events; other modes count system clocks.
// - Flag and enable both set raise the interrupt request.
// - Interval mode leaves the port bit as ordinary port bit.
// - Pulse mode toggles the line on underflow and 0x1A writes.
// - Pulse mode entry drives high; 0x1A write then drives low.
// - Event mode counts rising edges; source limited to half clock rate.
// - Width mode counts while line low, holds while high.
// - Width mode underflow sets flag, reloads, continues while low.
// - Serial channel needing internal clock forces clock-rate counting.
// - Receiver shift mode with external clock ignores this counter.
// - Serial bit rate is one sixteenth of the underflow rate.
module mmtc_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Processor bus
    input wire mmtc_pkg::mmtc_bus_t bus,
    output logic [7:0] rdata,
    // Control bits held elsewhere in the device
    input wire logic [1:0] mode_control_reg,
    input wire logic underflow_irq_enable,
    input wire mmtc_pkg::mmtc_serial_t serial,
    // Port A bit four pin and its general-purpose port values
    input wire logic port_a_bit_four_in,
    input wire logic port_a_bit_four_port_out,
    input wire logic port_a_bit_four_port_oe,
    output logic port_a_bit_four_out,
    output logic port_a_bit_four_oe,
    // Status outputs
    output logic underflow_flag,
    output logic irq_req,
    output logic serial_bit_strobe,
    output logic [15:0] count_value
);

    // ==========================================================
    // State
    // Count and reload latch halves
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [7:0] reload_low_byte_reg;
    logic [7:0] reload_high_byte_reg;

    // Underflow flag and pulse line
    logic flag_reg;
    logic flag_next;
    logic line_out_reg;
    logic line_out_next;

    // Registered outputs and the read data next value
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic pin_out_reg;
    logic pin_oe_reg;
    logic irq_reg;
    logic strobe_reg;

    // Mode at the previous edge and mode selected now
    mmtc_pkg::mmtc_mode_t mode_reg;
    mmtc_pkg::mmtc_mode_t mode_eff;

    // ==========================================================
    // Bus decode
    // Strobes are one cycle wide, so each decode is one access
    wire rd_low = bus.rd && (bus.addr == mmtc_pkg::ADDR_COUNT_LOW);
    wire rd_high = bus.rd && (bus.addr == mmtc_pkg::ADDR_COUNT_HIGH);
    wire wr_low = bus.wr && (bus.addr == mmtc_pkg::ADDR_COUNT_LOW);
    wire wr_high = bus.wr && (bus.addr == mmtc_pkg::ADDR_COUNT_HIGH);
    wire wr_restart = bus.wr && (bus.addr == mmtc_pkg::ADDR_HIGH_RESTART);

    // Mode bit decode
    // The bits are levels from the shared control register
    wire mode_select_lo = mode_control_reg[mmtc_pkg::MODE_SEL_LO_POS];
    wire mode_select_hi = mode_control_reg[mmtc_pkg::MODE_SEL_HI_POS];
    wire [1:0] mode_bits = {mode_select_hi, mode_select_lo};

    // Serial channel forcing internal clock counting
    // Shift mode runs the receiver from an outside clock instead
    wire serial_force = serial.enable && serial.needs_internal_clock
        && !serial.receiver_shift_mode;

    // ==========================================================
    // External line sampling
    logic line_level;
    logic line_rise;

    // Both samples reset high, the idle level of the pulled-up pin
    mmtc_edge_detect u_edge (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .line_in(port_a_bit_four_in),
        .level(line_level),
        .rise(line_rise)
    );

    // ==========================================================
    // Mode selection
    // Decode the mode bits into the one-hot mode
    // Every code is legal, so the case needs no default
    always_comb begin
        unique case (mode_bits)
            2'h0: mode_eff = mmtc_pkg::MMTC_INTERVAL;
            2'h1: mode_eff = mmtc_pkg::MMTC_PULSE_GEN;
            2'h2: mode_eff = mmtc_pkg::MMTC_EVENT;
            2'h3: mode_eff = mmtc_pkg::MMTC_WIDTH;
        endcase
    end

    // Count enable per mode; serial use forces clock-rate counting
    // The edge finder bounds event counting at half the clock rate
    // Width mode follows the sampled level, one cycle behind the pin
    logic count_en;

    always_comb begin
        count_en = 1'b1;
        if (!serial_force) begin
            unique case (mode_eff)
                mmtc_pkg::MMTC_INTERVAL: count_en = 1'b1;
                mmtc_pkg::MMTC_PULSE_GEN: count_en = 1'b1;
                mmtc_pkg::MMTC_EVENT: count_en = line_rise;
                mmtc_pkg::MMTC_WIDTH: count_en = ~line_level;
            endcase
        end
    end

    // ==========================================================
    // Count path
    // Underflow occurs when counting while holding zero
    wire underflow = count_en && (count_reg == mmtc_pkg::COUNT_ZERO);
    wire [15:0] full_latch = {reload_high_byte_reg, reload_low_byte_reg};
    wire [15:0] restart_value = {bus.wdata, reload_low_byte_reg};

    // Flag and pulse line events
    wire flag_clear = rd_low || wr_restart;
    wire pulse_toggle = wr_restart ^ underflow;

    // Next count value
    // A restart write beats an underflow in the same cycle
    // Holding keeps a measured width readable once the pulse ends
    always_comb begin
        if (wr_restart) begin
            count_next = restart_value;
        end else if (underflow) begin
            count_next = full_latch;
        end else if (count_en) begin
            count_next = count_reg - 16'h0001;
        end else begin
            count_next = count_reg;
        end
    end

    // ==========================================================
    // Underflow flag
    // Underflow flag: set wins over read clear
    // A clear that lands with an underflow must not lose it
    always_comb begin
        flag_next = flag_reg;
        if (flag_clear) begin
            flag_next = 1'b0;
        end
        if (underflow) begin
            flag_next = 1'b1;
        end
    end

    // ==========================================================
    // Pulse generation line
    // Pulse output line
    // Entry wins over a toggle so the first level is always high
    wire entering_pulse = (mode_eff == mmtc_pkg::MMTC_PULSE_GEN)
        && (mode_reg != mmtc_pkg::MMTC_PULSE_GEN);

    // A restart write and an underflow in one cycle cancel out
    always_comb begin
        line_out_next = line_out_reg;
        if (entering_pulse) begin
            line_out_next = 1'b1;
        end else if (mode_eff == mmtc_pkg::MMTC_PULSE_GEN) begin
            if (pulse_toggle) begin
                line_out_next = ~line_out_reg;
            end
        end
    end

    // ==========================================================
    // Register read path
    // Read data mux
    // Data holds between reads so software sees a steady byte
    always_comb begin
        rdata_next = rdata_reg;
        if (rd_high) begin
            rdata_next = count_reg[15:8];
        end else if (rd_low) begin
            rdata_next = count_reg[7:0];
        end
    end

    // ==========================================================
    // Shared port pin
    // Pin ownership: counter drives only in pulse mode
    // Event and width modes release the pin to the outside source
    // Pass-through port values arrive one cycle late, as the counter drive does
    wire pulse_own = (mode_eff == mmtc_pkg::MMTC_PULSE_GEN);
    wire input_own = (mode_eff == mmtc_pkg::MMTC_EVENT) || (mode_eff == mmtc_pkg::MMTC_WIDTH);
    wire pin_out_next = pulse_own ? line_out_next : port_a_bit_four_port_out;
    wire pin_oe_next = pulse_own ? 1'b1 : (input_own ? 1'b0 : port_a_bit_four_port_oe);

    // ==========================================================
    // Serial bit rate
    // Serial rate strobe
    // The divider clears when forcing drops, so each run starts aligned
    logic strobe_next;

    mmtc_rate_div u_rate (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .enable(serial_force),
        .tick(underflow),
        .bit_strobe(strobe_next)
    );

    // ==========================================================
    // Counter and latch
    // Count resets to zero and underflows on its first counting edge
    // Writes to 0x18 and 0x19 never touch the running count; a 0x1A write also loads it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_reg <= mmtc_pkg::COUNT_RESET;
            reload_low_byte_reg <= mmtc_pkg::LATCH_RESET[7:0];
            reload_high_byte_reg <= mmtc_pkg::LATCH_RESET[15:8];
        end else begin
            count_reg <= count_next;
            if (wr_low) begin
                reload_low_byte_reg <= bus.wdata;
            end
            if (wr_high || wr_restart) begin
                reload_high_byte_reg <= bus.wdata;
            end
        end
    end

    // ==========================================================
    // Flag, mode tracking and pulse line
    // The line resets high; every entry to pulse mode also forces it high
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flag_reg <= 1'b0;
            mode_reg <= mmtc_pkg::MMTC_INTERVAL;
            line_out_reg <= 1'b1;
        end else begin
            flag_reg <= flag_next;
            mode_reg <= mode_eff;
            line_out_reg <= line_out_next;
        end
    end

    // ==========================================================
    // Registered outputs
    // The request uses the next flag so it rises with the flag
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
            pin_out_reg <= 1'b1;
            pin_oe_reg <= 1'b0;
            irq_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
            irq_reg <= flag_next & underflow_irq_enable;
            strobe_reg <= strobe_next;
        end
    end

    // ==========================================================
    // Output drive
    // Every output leaves straight from a flip-flop
    assign rdata = rdata_reg;
    assign port_a_bit_four_out = pin_out_reg;
    assign port_a_bit_four_oe = pin_oe_reg;
    assign underflow_flag = flag_reg;
    assign irq_req = irq_reg;
    assign serial_bit_strobe = strobe_reg;
    assign count_value = count_reg;

endmodule : mmtc_top

// File: testbench/mmtc_line_model.sv
// Far side model: external event source on the shared counter line
module mmtc_line_model (
    // Clock
    input wire logic ref_clk,
    // Source control
    input wire logic run,
    input wire logic [3:0] half,
    // Counter side drive
    input wire logic oe,
    input wire logic out,
    output logic line
);
    timeunit 1ns;
    timeprecision 100ps;
    logic src = 1'b1;
    logic [3:0] n = 4'h0;
    // Toggle after half plus one cycles, so rising edges stay two clocks apart
    always @(posedge ref_clk) begin
        if (run && n >= half) begin
            n <= 4'h0;
            src <= !src;
        end else if (run) begin
            n <= n + 4'h1;
        end
    end
    // Pin level: counter drive, else source, else pull-up
    assign line = oe ? out : (run ? src : 1'b1);
endmodule : mmtc_line_model

// File: testbench/mmtc_monitor.sv
// Concurrent checks on the timer counter top ports
module mmtc_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bus and control
    input wire mmtc_pkg::mmtc_bus_t bus,
    input wire logic [7:0] rdata,
    input wire logic [1:0] mode_control_reg,
    input wire logic underflow_irq_enable,
    input wire mmtc_pkg::mmtc_serial_t serial,
    // Pin
    input wire logic port_a_bit_four_in,
    input wire logic port_a_bit_four_port_out,
    input wire logic port_a_bit_four_port_oe,
    input wire logic port_a_bit_four_out,
    input wire logic port_a_bit_four_oe,
    // Status
    input wire logic underflow_flag,
    input wire logic irq_req,
    input wire logic serial_bit_strobe,
    input wire logic [15:0] count_value
);
    // ==========================================================
    // Decodes
    logic w1a;
    logic nz;
    logic [1:0] md;
    assign w1a = bus.wr && bus.addr == 8'h1a;
    assign nz = count_value != 16'h0000;
    assign md = mode_control_reg;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Properties
    chk_count_down: assert property (md == 2'h0 && nz && !w1a |=>
        count_value == $past(count_value) - 16'h0001) else $error("count did not step down");
    chk_underflow_set: assert property (rst_n && md == 2'h0 && !nz |=> underflow_flag)
        else $error("underflow flag not set");
    chk_read_low: assert property (bus.rd && bus.addr == 8'h18 |=>
        rdata == $past(count_value[7:0])) else $error("low byte read wrong");
    chk_read_clear: assert property (bus.rd && bus.addr == 8'h18 && nz |=>
        !underflow_flag) else $error("low byte read kept flag");
    chk_restart_load: assert property (w1a && nz |=> !underflow_flag &&
        count_value[15:8] == $past(bus.wdata)) else $error("restart write wrong");
    chk_irq_flag: assert property ($past(rst_n) |->
        irq_req == (underflow_flag && $past(underflow_irq_enable))) else $error("irq wrong");
    chk_width_hold: assert property (md == 2'h3 && $past(port_a_bit_four_in) &&
        $past(rst_n) && !w1a && !serial.enable |=> $stable(count_value)) else $error("no hold");
    chk_port_pass: assert property (md == 2'h0 && $past(md) == 2'h0 && $past(rst_n) |->
        port_a_bit_four_oe == $past(port_a_bit_four_port_oe) &&
        port_a_bit_four_out == $past(port_a_bit_four_port_out)) else $error("port bit taken");
    chk_pulse_toggle: assert property (md == 2'h1 && $past(md) == 2'h1 && w1a && nz |=>
        port_a_bit_four_out != $past(port_a_bit_four_out)) else $error("pulse line kept");
endmodule : mmtc_monitor
bind mmtc_top mmtc_monitor mon (.ref_clk, .rst_n, .bus, .rdata, .mode_control_reg,
    .underflow_irq_enable, .serial, .port_a_bit_four_in, .port_a_bit_four_port_out,
    .port_a_bit_four_port_oe, .port_a_bit_four_out, .port_a_bit_four_oe, .underflow_flag,
    .irq_req, .serial_bit_strobe, .count_value);

// File: testbench/tb_top.sv
// Self-checking bench for the multimode timer counter
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Stimulus, outputs and reference state
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    mmtc_pkg::mmtc_bus_t bus = '0;
    mmtc_pkg::mmtc_serial_t serial = '0;
    logic [1:0] mode = 2'h3;
    logic en = 1'b0;
    logic p_out = 1'b0;
    logic p_oe = 1'b0;
    logic run = 1'b0;
    logic [3:0] half = 4'h1;
    logic [7:0] rdata;
    logic [15:0] cnt;
    logic pin, pout, poe, flag, irq, stb;
    int fails = 0, n_checks = 0, seed = 26, cyc = 0, ufs = 0, stbs = 0;
    int m_cnt = 0, m_lat = 0, m_rd = 0, s1 = 1, s2 = 1;
    bit m_flg = 0, m_irq = 0, on = 0, tk, fc, w1a, r18, uf;
    bit m_out = 1, m_oe = 0, m_ln = 1;
    int m_prev = 0;

    mmtc_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .mode_control_reg(mode), .underflow_irq_enable(en), .serial(serial),
        .port_a_bit_four_in(pin), .port_a_bit_four_port_out(p_out),
        .port_a_bit_four_port_oe(p_oe), .port_a_bit_four_out(pout),
        .port_a_bit_four_oe(poe), .underflow_flag(flag), .irq_req(irq),
        .serial_bit_strobe(stb), .count_value(cnt));
    mmtc_line_model far (.ref_clk(ref_clk), .run(run), .half(half), .oe(poe), .out(pout),
        .line(pin));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Reference model, fed with the values present at each edge
    always @(posedge ref_clk) begin
        fc = serial.enable && serial.needs_internal_clock && !serial.receiver_shift_mode;
        tk = fc || mode < 2 || (mode == 3 && s1 == 0) || (mode == 2 && s1 == 1 && s2 == 0);
        w1a = bus.wr && bus.addr == 8'h1a;
        r18 = bus.rd && bus.addr == 8'h18;
        uf = tk && m_cnt == 0;
        if (!rst_n) begin
            m_cnt = 0;
            m_lat = 0;
            m_flg = 0;
            m_irq = 0;
            m_rd = 0;
            m_out = 1;
            m_oe = 0;
            m_ln = 1;
            m_prev = 0;
        end else begin
            if (r18) m_rd = m_cnt % 256;
            if (bus.rd && bus.addr == 8'h19) m_rd = m_cnt / 256;
            m_flg = (tk && m_cnt == 0) || (m_flg && !r18 && !w1a);
            if (fc && tk && m_cnt == 0) ufs++;
            if (w1a) m_cnt = bus.wdata * 256 + m_lat % 256;
            else if (tk) m_cnt = (m_cnt == 0) ? m_lat : m_cnt - 1;
            if (bus.wr && bus.addr == 8'h18) m_lat = m_lat / 256 * 256 + bus.wdata;
            if (w1a || (bus.wr && bus.addr == 8'h19)) m_lat = m_lat % 256 + bus.wdata * 256;
            m_irq = m_flg && en;
            if (mode == 1 && m_prev != 1) m_ln = 1;
            else if (mode == 1 && (w1a ^ uf)) m_ln = !m_ln;
            m_prev = mode;
            m_out = (mode == 1) ? m_ln : p_out;
            m_oe = (mode == 1) ? 1'b1 : (mode[1] ? 1'b0 : p_oe);
        end
        if (stb === 1'b1) stbs++;
        s2 = s1;
        s1 = pin;
    end
    // Compare at every cycle once the counter is started
    always @(negedge ref_clk) begin
        if (on) begin
            cmp("count", m_cnt, cnt);
            cmp("flag", m_flg, flag);
            cmp("irq", m_irq, irq);
            cmp("rdata", m_rd, rdata);
            cmp("pin_out", m_out, pout);
            cmp("pin_oe", m_oe, poe);
        end
    end
    // Cycle ceiling
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 5000) begin
            fails++;
            complete_run();
        end
    end

    task automatic cmp(string what, int e, logic [15:0] g);
        n_checks++;
        if (g !== e[15:0]) begin
            fails++;
            $display("unexpected %s expected %0h seen %0h", what, e, g);
        end
    endtask : cmp
    // One bus access, held until the taking edge
    task automatic acc(bit w, logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk);
        bus.rd <= !w;
        bus.wr <= w;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        bus.wr <= 1'b0;
    endtask : acc
    // Random accesses over 0x18..0x1b, the last one unmapped
    task automatic rand_ops(int n);
        int r;
        for (int i = 0; i < n; i++) begin
            r = $random(seed);
            en <= r[8];
            p_out <= r[9];
            p_oe <= r[10];
            acc(r[4], 8'h18 + 8'(r[1:0]), (r[1:0] == 2'h0) ? {4'h0, r[15:12]} : 8'h00);
        end
    endtask : rand_ops
    task automatic complete_run();
        if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        acc(1, 8'h18, 8'h05);
        acc(1, 8'h1a, 8'h00);
        on <= 1'b1;
        mode <= 2'h0;
        rand_ops(40);
        acc(1, 8'h1a, 8'h04);
        mode <= 2'h1;
        repeat (3) @(posedge ref_clk);
        #1 cmp("pulse_entry", 1, pout);
        acc(1, 8'h1a, 8'h04);
        #1 cmp("pulse_start", 0, pout);
        cmp("pulse_oe", 1, poe);
        rand_ops(30);
        for (int m = 2; m < 4; m++) begin
            mode <= m[1:0];
            run <= 1'b1;
            half <= 4'($random(seed) & 3);
            rand_ops(30);
        end
        run <= 1'b0;
        mode <= 2'h2;
        acc(1, 8'h18, 8'h01);
        acc(1, 8'h1a, 8'h00);
        serial <= 3'b110;
        repeat (200) @(posedge ref_clk);
        serial.receiver_shift_mode <= 1'b1;
        repeat (20) @(posedge ref_clk);
        cmp("strobes", ufs / 16, 16'(stbs));
        serial <= '0;
        mode <= 2'h0;
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        complete_run();
    end
endmodule : tb_top
